// ==== common/rds_pkg.sv ====
// package for the receive descriptor slot bank: offsets, field positions, reset values
// assumes an 8-bit host register bus with 8-bit offsets and one 100 MHz clock
package rds_pkg;
    localparam int          NUM_SLOTS      = 8;
    localparam int          SLOT_IDX_W     = 3;
    // host register offsets
    localparam logic [7:0]  OFF_HEAD_HIGH  = 8'h17;
    localparam logic [7:0]  OFF_INFO_HIGH0 = 8'h23;
    localparam logic [7:0]  OFF_INFO_LOW0  = 8'h24;
    localparam logic [7:0]  OFF_LEN_HIGH0  = 8'h25;
    localparam logic [7:0]  OFF_LEN_LOW0   = 8'h26;
    localparam logic [7:0]  OFF_ADDR_HIGH0 = 8'h27;
    localparam logic [7:0]  OFF_ADDR_LOW0  = 8'h28;
    localparam logic [7:0]  SLOT_STRIDE    = 8'h06;
    // field offsets inside one slot's six-byte window, relative to info high
    localparam logic [2:0]  FLD_INFO_HIGH  = 3'h0;
    localparam logic [2:0]  FLD_INFO_LOW   = 3'h1;
    localparam logic [2:0]  FLD_LEN_HIGH   = 3'h2;
    localparam logic [2:0]  FLD_LEN_LOW    = 3'h3;
    localparam logic [2:0]  FLD_ADDR_HIGH  = 3'h4;
    localparam logic [2:0]  FLD_ADDR_LOW   = 3'h5;
    // information low byte bit positions
    localparam int          BIT_GOOD       = 7;
    localparam int          BIT_TYPE       = 6;
    localparam int          BIT_LEN_MISM   = 5;
    localparam int          BIT_FCS_FAIL   = 4;
    localparam int          BIT_RUNT       = 1;
    localparam int          BIT_DROPPED    = 0;
    // information high byte bit positions
    localparam int          BIT_TAGGED     = 6;
    localparam int          BIT_UNSUP_CTL  = 5;
    localparam int          BIT_PAUSE      = 4;
    localparam int          BIT_CONTROL    = 3;
    localparam int          BIT_TRAILING   = 2;
    localparam int          BIT_BROADCAST_FLAG      = 1;
    localparam int          BIT_MULTICAST_FLAG      = 0;
    // reset values and the value read at unmapped offsets
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
endpackage : rds_pkg

// ==== hw/rds_slot.sv ====
// one receive descriptor slot: flags, length and start address of one packet
// assumes claim and complete are one-cycle pulses from the slot allocator
`timescale 1ns/1ns
module rds_slot (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        claim_in,
    input  wire logic [15:0] start_addr_in,
    input  wire logic        complete_in,
    input  wire logic [7:0]  info_high_in,
    input  wire logic [7:0]  info_low_in,
    input  wire logic [15:0] length_in,
    output logic      [7:0]  info_high_out,
    output logic      [7:0]  info_low_out,
    output logic      [15:0] length_out,
    output logic      [15:0] start_addr_out
);
    logic [7:0]  next_info_high;
    logic [7:0]  next_info_low;
    logic [15:0] next_length;
    logic [15:0] next_start_addr;

    // values hold until the slot is reused, so debug reads stay coherent
    always_comb begin
        next_info_high  = info_high_out;
        next_info_low   = info_low_out;
        next_length     = length_out;
        next_start_addr = start_addr_out;
        if (claim_in) begin
            next_start_addr = start_addr_in;
        end
        if (complete_in) begin
            next_info_high = info_high_in;
            next_info_low  = info_low_in;
            next_length    = length_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            info_high_out  <= rds_pkg::RST_BYTE;
            info_low_out   <= rds_pkg::RST_BYTE;
            length_out     <= rds_pkg::RST_WORD;
            start_addr_out <= rds_pkg::RST_WORD;
        end else begin
            info_high_out  <= next_info_high;
            info_low_out   <= next_info_low;
            length_out     <= next_length;
            start_addr_out <= next_start_addr;
        end
    end
endmodule : rds_slot

// ==== hw/rds_bank.sv ====
// receive descriptor slot bank with slot allocation, current slot and head pointer
// assumes the receive filter gives start/done pulses and the host bus is synchronous
`timescale 1ns/1ns
module rds_bank #(
    parameter int NUM_SLOTS = rds_pkg::NUM_SLOTS
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // host register port
    input  wire logic [7:0]  host_addr_in,
    input  wire logic        host_rd_in,
    input  wire logic        host_wr_in,
    input  wire logic [7:0]  host_wdata_in,
    output logic      [7:0]  host_rdata_out,
    // receive side
    input  wire logic        pkt_start_in,
    input  wire logic [15:0] tail_ptr_in,
    input  wire logic        pkt_done_in,
    input  wire logic [15:0] pkt_length_in,
    input  wire logic        receive_good_flag_in,
    input  wire logic        type_field_flag_in,
    input  wire logic        length_mismatch_flag_in,
    input  wire logic        fcs_fail_flag_in,
    input  wire logic        runt_flag_in,
    input  wire logic        dropped_flag_in,
    input  wire logic        tagged_frame_flag_in,
    input  wire logic        unsupported_control_flag_in,
    input  wire logic        pause_frame_flag_in,
    input  wire logic        control_frame_flag_in,
    input  wire logic        trailing_data_flag_in,
    input  wire logic        broadcast_flag_in,
    input  wire logic        multicast_flag_in,
    // neighbouring control
    input  wire logic [7:0]  slot_valid_clear_in,
    input  wire logic        autoread_in,
    output logic      [7:0]  slot_valid_bits_out,
    output logic      [2:0]  current_slot_number_out,
    output logic      [15:0] head_ptr_out,
    output logic             pkt_drop_out
);
    logic [7:0]  slot_info_high [NUM_SLOTS];
    logic [7:0]  slot_info_low  [NUM_SLOTS];
    logic [15:0] slot_length    [NUM_SLOTS];
    logic [15:0] slot_start     [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] claim_pulse;
    logic [NUM_SLOTS-1:0] complete_pulse;
    logic [7:0]  info_high_word;
    logic [7:0]  info_low_word;

    // allocator state
    logic [2:0]  alloc_ptr;
    logic [2:0]  fill_slot;
    logic        fill_active;
    logic [15:0] read_count;
    logic [7:0]  next_valid;
    logic [2:0]  next_alloc_ptr;
    logic [2:0]  next_fill_slot;
    logic        next_fill_active;
    logic [2:0]  next_current;
    logic [15:0] next_read_count;
    logic [15:0] next_head;
    logic        next_drop;
    logic [7:0]  next_rdata;

    // first free slot at or after the rotating pointer, so slots are reused in circle
    function automatic logic [3:0] first_free(input logic [7:0] valid,
                                              input logic [2:0] from);
        logic [3:0] found;
        logic [2:0] idx;
        found = 4'h8;
        for (int k = 7; k >= 0; k--) begin
            idx = from + 3'(k);
            if (!valid[idx]) begin
                found = {1'b0, idx};
            end
        end
        return found;
    endfunction : first_free

    // is this offset a slot byte; returns {hit, slot, field}
    function automatic logic [6:0] slot_decode(input logic [7:0] addr);
        logic [6:0] res;
        logic [7:0] rel;
        res = 7'h00;
        rel = addr - rds_pkg::OFF_INFO_HIGH0;
        for (int s = 0; s < 8; s++) begin
            if (rel >= 8'(s) * rds_pkg::SLOT_STRIDE
                && rel < 8'(s + 1) * rds_pkg::SLOT_STRIDE
                && addr >= rds_pkg::OFF_INFO_HIGH0) begin
                res = {1'b1, 3'(s), 3'(rel - 8'(s) * rds_pkg::SLOT_STRIDE)};
            end
        end
        return res;
    endfunction : slot_decode

    // descriptor words as stored; reserved low bits stored as zero
    assign info_low_word = {receive_good_flag_in,
                            type_field_flag_in,
                            length_mismatch_flag_in,
                            fcs_fail_flag_in,
                            2'b00,
                            runt_flag_in,
                            dropped_flag_in};
    assign info_high_word = {1'b0,
                             tagged_frame_flag_in,
                             unsupported_control_flag_in,
                             pause_frame_flag_in,
                             control_frame_flag_in,
                             trailing_data_flag_in,
                             broadcast_flag_in,
                             multicast_flag_in};

    // slot storage, one instance per slot
    generate
        for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
            assign claim_pulse[g]    = pkt_start_in && (first_free(slot_valid_bits_out,
                                       alloc_ptr) == 4'(g));
            assign complete_pulse[g] = pkt_done_in && fill_active && (fill_slot == 3'(g));
            rds_slot u_slot (
                .clk_in         (clk_in),
                .rst_in         (rst_in),
                .claim_in       (claim_pulse[g]),
                .start_addr_in  (tail_ptr_in),
                .complete_in    (complete_pulse[g]),
                .info_high_in   (info_high_word),
                .info_low_in    (info_low_word),
                .length_in      (pkt_length_in),
                .info_high_out  (slot_info_high[g]),
                .info_low_out   (slot_info_low[g]),
                .length_out     (slot_length[g]),
                .start_addr_out (slot_start[g])
            );
        end
    endgenerate

    // allocation, current slot and head pointer
    always_comb begin
        logic [3:0] free_idx;
        free_idx         = first_free(slot_valid_bits_out, alloc_ptr);
        next_valid       = slot_valid_bits_out & ~slot_valid_clear_in;
        next_alloc_ptr   = alloc_ptr;
        next_fill_slot   = fill_slot;
        next_fill_active = fill_active;
        next_current     = current_slot_number_out;
        next_read_count  = read_count;
        next_head        = head_ptr_out;
        next_drop        = 1'b0;
        if (pkt_done_in) begin
            next_fill_active = 1'b0;
        end
        // a claim in the same cycle as a clear still sets the bit
        if (pkt_start_in) begin
            if (free_idx[3]) begin
                next_drop        = 1'b1;
                next_fill_active = 1'b0;
            end else begin
                next_valid[free_idx[2:0]] = 1'b1;
                next_fill_slot   = free_idx[2:0];
                next_fill_active = 1'b1;
                next_alloc_ptr   = free_idx[2:0] + 3'h1;
            end
        end
        // oldest packet moves on once its valid bit is released
        if (slot_valid_bits_out[current_slot_number_out]
            && slot_valid_clear_in[current_slot_number_out]) begin
            next_current    = current_slot_number_out + 3'h1;
            next_read_count = rds_pkg::RST_WORD;
        end else if (autoread_in && slot_valid_bits_out[current_slot_number_out]
                     && read_count < slot_length[current_slot_number_out]) begin
            next_head       = head_ptr_out + 16'h0001;
            next_read_count = read_count + 16'h0001;
        end
        // host write to the high byte overrides the increment's carry
        if (host_wr_in && host_addr_in == rds_pkg::OFF_HEAD_HIGH) begin
            next_head[15:8] = host_wdata_in;
        end
    end

    // host read mux; slot bytes are read only, writes to them fall through
    always_comb begin
        logic [6:0] dec;
        logic [2:0] s;
        dec        = slot_decode(host_addr_in);
        s          = dec[5:3];
        next_rdata = rds_pkg::UNMAPPED_READ;
        if (host_rd_in) begin
            if (host_addr_in == rds_pkg::OFF_HEAD_HIGH) begin
                next_rdata = head_ptr_out[15:8];
            end else if (dec[6]) begin
                case (dec[2:0])
                    rds_pkg::FLD_INFO_HIGH: next_rdata = slot_info_high[s];
                    rds_pkg::FLD_INFO_LOW:  next_rdata = slot_info_low[s];
                    rds_pkg::FLD_LEN_HIGH:  next_rdata = slot_length[s][15:8];
                    rds_pkg::FLD_LEN_LOW:   next_rdata = slot_length[s][7:0];
                    rds_pkg::FLD_ADDR_HIGH: next_rdata = slot_start[s][15:8];
                    rds_pkg::FLD_ADDR_LOW:  next_rdata = slot_start[s][7:0];
                    default:                next_rdata = rds_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    // register every piece of state and every output
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            slot_valid_bits_out     <= rds_pkg::RST_BYTE;
            alloc_ptr               <= 3'h0;
            fill_slot               <= 3'h0;
            fill_active             <= 1'b0;
            current_slot_number_out <= 3'h0;
            read_count              <= rds_pkg::RST_WORD;
            head_ptr_out            <= rds_pkg::RST_WORD;
            pkt_drop_out            <= 1'b0;
            host_rdata_out          <= rds_pkg::RST_BYTE;
        end else begin
            slot_valid_bits_out     <= next_valid;
            alloc_ptr               <= next_alloc_ptr;
            fill_slot               <= next_fill_slot;
            fill_active             <= next_fill_active;
            current_slot_number_out <= next_current;
            read_count              <= next_read_count;
            head_ptr_out            <= next_head;
            pkt_drop_out            <= next_drop;
            host_rdata_out          <= next_rdata;
        end
    end
endmodule : rds_bank

// ==== test/rds_bank_properties.sv ====
// checker for the descriptor slot bank, watching only the top module's ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
module rds_bank_properties (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  host_addr_in,
    input wire logic        host_rd_in,
    input wire logic        host_wr_in,
    input wire logic [7:0]  host_wdata_in,
    input wire logic [7:0]  host_rdata_out,
    input wire logic        pkt_start_in,
    input wire logic [7:0]  slot_valid_clear_in,
    input wire logic        autoread_in,
    input wire logic [7:0]  slot_valid_bits_out,
    input wire logic [15:0] head_ptr_out,
    input wire logic        pkt_drop_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // read data is only driven in the cycle after a read strobe
    a_idle_read_zero: assert property (!host_rd_in |=> host_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    a_head_read_back: assert property (host_rd_in && host_addr_in == 8'h17
        |=> host_rdata_out == $past(head_ptr_out[15:8])) else $error("head high read wrong");
    a_head_high_write: assert property (host_wr_in && host_addr_in == 8'h17 && !autoread_in
        |=> head_ptr_out == {$past(host_wdata_in), $past(head_ptr_out[7:0])})
        else $error("head high write not taken");
    // head moves only through auto-read or a host write, and auto-read moves it by one at most
    a_head_holds: assert property (!autoread_in && !host_wr_in |=> $stable(head_ptr_out))
        else $error("head moved without cause");
    a_head_step_one: assert property (autoread_in && !host_wr_in
        |=> head_ptr_out == $past(head_ptr_out) || head_ptr_out == $past(head_ptr_out) + 16'h0001)
        else $error("head stepped by more than one");
    // a claim with a free slot adds exactly one valid bit and no drop
    a_claim_adds_one: assert property (pkt_start_in && slot_valid_bits_out != 8'hff
        && slot_valid_clear_in == 8'h00
        |=> $countones(slot_valid_bits_out) == $countones($past(slot_valid_bits_out)) + 1
        && !pkt_drop_out) else $error("claim did not take one slot");
    a_drop_when_full: assert property (pkt_start_in && slot_valid_bits_out == 8'hff
        && slot_valid_clear_in == 8'h00 |=> pkt_drop_out ##1 !pkt_drop_out || pkt_start_in)
        else $error("full bank did not drop");
    a_clear_empties: assert property (slot_valid_clear_in != 8'h00 && !pkt_start_in
        |=> (slot_valid_bits_out & $past(slot_valid_clear_in)) == 8'h00)
        else $error("valid bit not cleared");
    a_valid_holds: assert property (!pkt_start_in && slot_valid_clear_in == 8'h00
        |=> $stable(slot_valid_bits_out)) else $error("valid bits moved without cause");
endmodule : rds_bank_properties

// ==== test/rds_host_model.sv ====
// host processor model on the parallel register port: single-byte reads and writes
// assumes the bank answers a read one cycle after the strobe
`timescale 1ns/1ns
module rds_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] host_rdata_in,
    output logic      [7:0] host_addr_out,
    output logic            host_rd_out,
    output logic            host_wr_out,
    output logic      [7:0] host_wdata_out
);
    initial begin
        host_addr_out = 8'h00;
        host_rd_out = 1'b0;
        host_wr_out = 1'b0;
        host_wdata_out = 8'h00;
    end

    // single-byte read: strobe for one cycle, then take the read data one cycle after the strobe
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_in);
        #1 host_addr_out = addr;
        host_rd_out = 1'b1;
        @(posedge clk_in);
        #1 host_rd_out = 1'b0;
        data = host_rdata_in;
    endtask : read_reg

    // data lines toggle once released so stale bytes are never mistaken for a write
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        #1 host_addr_out = addr;
        host_wdata_out = data;
        host_wr_out = 1'b1;
        @(posedge clk_in);
        #1 host_wr_out = 1'b0;
        host_wdata_out = ~data;
    endtask : write_reg
endmodule : rds_host_model

// ==== test/rds_bank_tb.sv ====
// self-checking bench for the descriptor slot bank
// assumes the host model drives the register port; receive side is driven here
`timescale 1ns/1ns
module rds_bank_tb;
    typedef struct packed {
        logic [15:0] tail;
        logic [15:0] len;
        logic [12:0] fl;
    } rds_row_s;
    logic        clk_in, rst_in, host_rd, host_wr, pkt_start, pkt_done, autoread, drop;
    logic [7:0]  host_addr, host_wdata, host_rdata, valid_bits, vclr, b;
    logic [15:0] tail, len, head;
    logic [12:0] fl;
    logic [2:0]  cur;
    int          failures, check_count;
    rds_row_s    rows [8];

    rds_bank i_dut (.clk_in(clk_in), .rst_in(rst_in), .host_addr_in(host_addr),
        .host_rd_in(host_rd), .host_wr_in(host_wr), .host_wdata_in(host_wdata),
        .host_rdata_out(host_rdata), .pkt_start_in(pkt_start), .tail_ptr_in(tail),
        .pkt_done_in(pkt_done), .pkt_length_in(len), .receive_good_flag_in(fl[12]),
        .type_field_flag_in(fl[11]), .length_mismatch_flag_in(fl[10]),
        .fcs_fail_flag_in(fl[9]), .runt_flag_in(fl[8]), .dropped_flag_in(fl[7]),
        .tagged_frame_flag_in(fl[6]), .unsupported_control_flag_in(fl[5]),
        .pause_frame_flag_in(fl[4]), .control_frame_flag_in(fl[3]),
        .trailing_data_flag_in(fl[2]), .broadcast_flag_in(fl[1]), .multicast_flag_in(fl[0]),
        .slot_valid_clear_in(vclr), .autoread_in(autoread), .slot_valid_bits_out(valid_bits),
        .current_slot_number_out(cur), .head_ptr_out(head), .pkt_drop_out(drop));
    rds_host_model i_host (.clk_in(clk_in), .host_rdata_in(host_rdata),
        .host_addr_out(host_addr), .host_rd_out(host_rd), .host_wr_out(host_wr),
        .host_wdata_out(host_wdata));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        i_host.read_reg(addr, got);
        check($sformatf("register %h", addr), {8'h00, exp}, {8'h00, got});
    endtask : expect_reg

    // every slot byte and the head high byte read zero out of reset
    task automatic zero_check;
        expect_reg(8'h17, 8'h00);
        for (int a = 8'h23; a <= 8'h52; a++) expect_reg(8'(a), 8'h00);
    endtask : zero_check

    // one claim pulse then one completion pulse, back to back
    task automatic receive(input rds_row_s r);
        @(posedge clk_in);
        #1 pkt_start = 1'b1;
        tail = r.tail;
        @(posedge clk_in);
        #1 pkt_start = 1'b0;
        pkt_done = 1'b1;
        len = r.len;
        fl = r.fl;
        @(posedge clk_in);
        #1 pkt_done = 1'b0;
    endtask : receive

    task automatic conclude;
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // cut a hang short well past the expected run of about 350 cycles
    initial begin
        #100000;
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        check_count = 0;
        // reset is raised on its own so that no signal is assigned twice at time zero
        rst_in = 1'b1;
        {pkt_start, pkt_done, autoread, vclr, tail, len, fl} = '0;
        repeat (4) @(posedge clk_in);
        #1 rst_in = 1'b0;
        zero_check();
        // each row but row 6 sets two flags so that all thirteen flags appear at least once
        for (int i = 0; i < 8; i++) begin
            rows[i] = {16'h1234 + 16'(i * 16'h1111), 16'h0100 + 16'(i * 16'h0101),
                       13'(13'h0001 << i) | 13'(13'h1000 >> i)};
            receive(rows[i]);
        end
        for (int i = 0; i < 8; i++) begin
            b = 8'h23 + 8'(6 * i);
            expect_reg(b, {1'b0, rows[i].fl[6:0]});
            expect_reg(b + 8'h01, {rows[i].fl[12:9], 2'b00, rows[i].fl[8:7]});
            expect_reg(b + 8'h02, rows[i].len[15:8]);
            expect_reg(b + 8'h03, rows[i].len[7:0]);
            expect_reg(b + 8'h04, rows[i].tail[15:8]);
            expect_reg(b + 8'h05, rows[i].tail[7:0]);
        end
        check("valid bits", 16'h00ff, {8'h00, valid_bits});
        // ninth packet with all slots taken is dropped and overwrites nothing
        @(posedge clk_in);
        #1 pkt_start = 1'b1;
        tail = 16'hbeef;
        @(posedge clk_in);
        #1 pkt_start = 1'b0;
        check("drop pulse", 16'h0001, {15'h0000, drop});
        receive({16'hbeef, 16'hffff, 13'h1fff});
        expect_reg(8'h25, rows[0].len[15:8]);
        expect_reg(8'h27, rows[0].tail[15:8]);
        // slot bytes ignore host writes, head high byte takes them
        i_host.write_reg(8'h26, 8'h5a);
        expect_reg(8'h26, rows[0].len[7:0]);
        i_host.write_reg(8'h17, 8'ha5);
        expect_reg(8'h17, 8'ha5);
        @(posedge clk_in);
        #1 autoread = 1'b1;
        repeat (3) @(posedge clk_in);
        #1 autoread = 1'b0;
        check("head pointer", 16'ha503, head);
        // freeing the oldest slot moves the current slot on and lets a claim reuse it
        vclr = 8'h01;
        @(posedge clk_in);
        #1 vclr = 8'h00;
        @(posedge clk_in);
        #1 check("current slot", 16'h0001, {13'h0000, cur});
        check("valid after clear", 16'h00fe, {8'h00, valid_bits});
        pkt_start = 1'b1;
        tail = 16'h4321;
        @(posedge clk_in);
        #1 pkt_start = 1'b0;
        expect_reg(8'h27, 8'h43);
        expect_reg(8'h25, rows[0].len[15:8]);
        // second reset in mid-run clears everything again
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        check("valid after reset", 16'h0000, {8'h00, valid_bits});
        zero_check();
        conclude();
    end
endmodule : rds_bank_tb

bind rds_bank rds_bank_properties i_props (.clk_in, .rst_in, .host_addr_in, .host_rd_in,
    .host_wr_in, .host_wdata_in, .host_rdata_out, .pkt_start_in, .slot_valid_clear_in,
    .autoread_in, .slot_valid_bits_out, .head_ptr_out, .pkt_drop_out);
